// ---- design/pais_defines.vh ----
// Register map, field positions, reset values and timing for input select
`ifndef PAIS_DEFINES_VH
`define PAIS_DEFINES_VH
// Register offsets
`define PAIS_OFF_AMB_ENC 8'h06
`define PAIS_OFF_PROX1_SEL 8'h07
`define PAIS_OFF_PROX2_SEL 8'h08
`define PAIS_OFF_PROX3_SEL 8'h09
`define PAIS_OFF_REC_CNT 8'h0a
`define PAIS_OFF_GAIN 8'h0b
`define PAIS_OFF_MISC 8'h0c
`define PAIS_OFF_STATUS 8'h0d
// Reset values
`define PAIS_RST_AMB_ENC 8'h00
`define PAIS_RST_SEL 8'h03
`define PAIS_RST_REC_CNT 8'h70
`define PAIS_RST_GAIN 8'h00
`define PAIS_RST_MISC 8'h04
// Field positions and write masks
`define PAIS_ALIGN_BIT 4
`define PAIS_REC_LSB 4
`define PAIS_MODE_BIT 2
`define PAIS_MASK_AMB_ENC 8'h10
`define PAIS_MASK_REC_CNT 8'h70
`define PAIS_MASK_GAIN 8'h07
`define PAIS_MASK_MISC 8'h04
// Converter input codes
`define PAIS_IN_SMALL_IR 8'h00
`define PAIS_IN_VISIBLE 8'h02
`define PAIS_IN_LARGE_IR 8'h03
`define PAIS_IN_NO_PD 8'h06
`define PAIS_IN_GND 8'h25
`define PAIS_IN_TEMP 8'h65
`define PAIS_IN_VDD 8'h75
// Route codes presented to the converter front end
`define PAIS_RT_SMALL_IR 3'h0
`define PAIS_RT_LARGE_IR 3'h1
`define PAIS_RT_VISIBLE 3'h2
`define PAIS_RT_NO_PD 3'h3
`define PAIS_RT_GND 3'h4
`define PAIS_RT_TEMP 3'h5
`define PAIS_RT_VDD 3'h6
`define PAIS_RT_NONE 3'h7
// One recovery converter clock at unity gain, and system clock period
`define PAIS_REC_CLK_NS 50
`define PAIS_SYS_CLK_NS 5
`define PAIS_REC_TICK_CYC (`PAIS_REC_CLK_NS / `PAIS_SYS_CLK_NS)
`endif

// ---- design/pais_input_select.v ----
// Proximity converter input select, recovery timing and result alignment
// Operation
// [R01] Align bit set: report low 16 bits
// [R02] Normal mode: 0x03 large, 0x00 small IR
// [R03] Raw mode: LEDs off, no reference
// [R04] Raw mode adds visible and no-photodiode codes
// [R05] Raw mode adds ground and temperature codes
// [R06] Host negates visible minus no-photodiode
// [R07] Host subtracts ground; temperature relative only
// [R08] Channels two and three decode like one
// [R09] Normal proximity mode is reset default
// [R10] Recovery code selects 1 to 511 clocks
// [R11] Recovery clock 50 ns, scaled by gain
// [R12] Host sets recovery as complement of gain
// [R13] Gain doubles LED pulse and integration
// [R14] Mode bit: 0 raw, 1 normal
`timescale 1ns/1ps
`include "pais_defines.vh"
module pais_input_select #(
  parameter TICK_CYC = `PAIS_REC_TICK_CYC
) (
  input wire sys_clk,
  input wire srst,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [7:0] regRdData,
  // Sequencer side
  input wire convStart,
  input wire [1:0] convChannel,
  input wire [16:0] convRaw,
  input wire convRawValid,
  input wire ambientVisActive,
  output reg [2:0] adcRoute,
  output reg selValid,
  output reg ledEnable,
  output reg recoveryBusy,
  output reg recoveryDone,
  output reg [15:0] ambientResult,
  output reg ambientResultValid,
  output reg [2:0] integScale
);

  // ***************************************************************
  // Code decode
  // ***************************************************************

  // Map a selector code to a route; mode decides which codes are legal
  function [3:0] decodeSel;
    input [7:0] code;
    input normalMode;
    begin
      decodeSel = {1'b0, `PAIS_RT_NONE};
      case (code)
        `PAIS_IN_LARGE_IR: decodeSel = {1'b1, `PAIS_RT_LARGE_IR}; // R02
        `PAIS_IN_SMALL_IR: decodeSel = {1'b1, `PAIS_RT_SMALL_IR}; // R02
        `PAIS_IN_VISIBLE: begin
          if (!normalMode) decodeSel = {1'b1, `PAIS_RT_VISIBLE}; // R04
        end
        `PAIS_IN_NO_PD: begin
          if (!normalMode) decodeSel = {1'b1, `PAIS_RT_NO_PD}; // R04
        end
        `PAIS_IN_GND: begin
          if (!normalMode) decodeSel = {1'b1, `PAIS_RT_GND}; // R05
        end
        `PAIS_IN_TEMP: begin
          if (!normalMode) decodeSel = {1'b1, `PAIS_RT_TEMP}; // R05
        end
        `PAIS_IN_VDD: begin
          if (!normalMode) decodeSel = {1'b1, `PAIS_RT_VDD};
        end
        default: decodeSel = {1'b0, `PAIS_RT_NONE};
      endcase
    end
  endfunction

  // Recovery length in converter clocks: 2^(code+2)-1, code 0 gives 1
  // Code 0 breaks the pattern, so it is caught before the shift
  function [9:0] recClocks;
    input [2:0] code;
    begin
      if (code == 3'h0) begin
        recClocks = 10'h001;
      end else begin
        recClocks = (10'h004 << code) - 10'h001; // R10
      end
    end
  endfunction

  // ***************************************************************
  // Registers
  // ***************************************************************

  reg [7:0] ambEnc_reg;
  reg [7:0] prox1Sel_reg;
  reg [7:0] prox2Sel_reg;
  reg [7:0] prox3Sel_reg;
  reg [7:0] recCnt_reg;
  reg [7:0] gain_reg;
  reg [7:0] misc_reg;
  reg [7:0] rdData_next;
  wire normalMode;
  wire [2:0] recCode;
  wire [2:0] gainExp;

  assign normalMode = misc_reg[`PAIS_MODE_BIT]; // R14
  assign recCode = recCnt_reg[`PAIS_REC_LSB+2:`PAIS_REC_LSB];
  assign gainExp = gain_reg[2:0];

  // Writes; reserved bits are masked so they read as zero
  // Selectors keep all eight bits: an illegal code is stored as written
  // and simply decodes as no route, so software reads back what it wrote
  always @(posedge sys_clk) begin
    if (srst) begin
      ambEnc_reg <= `PAIS_RST_AMB_ENC;
      prox1Sel_reg <= `PAIS_RST_SEL;
      prox2Sel_reg <= `PAIS_RST_SEL;
      prox3Sel_reg <= `PAIS_RST_SEL;
      recCnt_reg <= `PAIS_RST_REC_CNT;
      gain_reg <= `PAIS_RST_GAIN;
      misc_reg <= `PAIS_RST_MISC; // R09
    end else if (regWrStb) begin
      case (regAddr)
        `PAIS_OFF_AMB_ENC: ambEnc_reg <= regWrData & `PAIS_MASK_AMB_ENC;
        `PAIS_OFF_PROX1_SEL: prox1Sel_reg <= regWrData;
        `PAIS_OFF_PROX2_SEL: prox2Sel_reg <= regWrData;
        `PAIS_OFF_PROX3_SEL: prox3Sel_reg <= regWrData;
        `PAIS_OFF_REC_CNT: recCnt_reg <= regWrData & `PAIS_MASK_REC_CNT;
        `PAIS_OFF_GAIN: gain_reg <= regWrData & `PAIS_MASK_GAIN;
        `PAIS_OFF_MISC: misc_reg <= regWrData & `PAIS_MASK_MISC;
        default: ambEnc_reg <= ambEnc_reg;
      endcase
    end
  end

  // ***************************************************************
  // Recovery sequencer
  // ***************************************************************

  localparam ST_IDLE = 2'h0;
  localparam ST_REC = 2'h1;
  localparam ST_CONV = 2'h2;

  reg [1:0] state_reg;
  reg [7:0] tick_reg;
  reg [6:0] scale_reg;
  reg [9:0] recLeft_reg;
  reg [1:0] chan_reg;
  wire [3:0] dec0;
  wire [3:0] dec1;
  wire [3:0] dec2;
  reg [3:0] decSel;
  wire tickEnd;

  // All three channels share one decoder, same mode dependence
  assign dec0 = decodeSel(prox1Sel_reg, normalMode); // R08
  assign dec1 = decodeSel(prox2Sel_reg, normalMode); // R08
  assign dec2 = decodeSel(prox3Sel_reg, normalMode); // R08

  // Channel select of the pending conversion
  always @* begin
    case (chan_reg)
      2'h1: decSel = dec1;
      2'h2: decSel = dec2;
      default: decSel = dec0;
    endcase
  end

  // Base tick: one 50 ns step stretched by 2^gain
  // Tick counter is eight bits, so TICK_CYC may not exceed 256
  assign tickEnd = (tick_reg == TICK_CYC[7:0] - 8'h01) &&
    (scale_reg == 7'h00); // R11

  // Recovery wait then conversion window; a new start during a run is
  // ignored, the sequencer never overlaps two channels
  // Gain 7 wraps the 7-bit shift to zero; the subtraction then lands on
  // all ones, which is exactly the 127 extra ticks that are wanted
  always @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      tick_reg <= 8'h00;
      scale_reg <= 7'h00;
      recLeft_reg <= 10'h000;
      chan_reg <= 2'h0;
      recoveryBusy <= 1'b0;
      recoveryDone <= 1'b0;
    end else begin
      recoveryDone <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (convStart) begin
            chan_reg <= convChannel;
            recLeft_reg <= recClocks(recCode); // R10
            tick_reg <= 8'h00;
            scale_reg <= (7'h01 << gainExp) - 7'h01; // R11
            recoveryBusy <= 1'b1;
            state_reg <= ST_REC;
          end
        end
        ST_REC: begin
          if (tick_reg != TICK_CYC[7:0] - 8'h01) begin
            tick_reg <= tick_reg + 8'h01;
          end else begin
            tick_reg <= 8'h00;
            if (scale_reg != 7'h00) begin
              scale_reg <= scale_reg - 7'h01;
            end else begin
              scale_reg <= (7'h01 << gainExp) - 7'h01;
            end
          end
          if (tickEnd) begin
            if (recLeft_reg == 10'h001) begin
              recoveryBusy <= 1'b0;
              recoveryDone <= 1'b1;
              state_reg <= ST_CONV;
            end
            recLeft_reg <= recLeft_reg - 10'h001;
          end
        end
        ST_CONV: begin
          // Converter owns the channel until its result lands
          if (convRawValid) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // Outputs to the converter front end
  // ***************************************************************

  // Route and LED enable held from flops; raw mode kills LED drive
  // Route follows the latched channel, not convChannel, so the front end
  // only moves between channels when a new recovery is started
  always @(posedge sys_clk) begin
    if (srst) begin
      adcRoute <= `PAIS_RT_LARGE_IR;
      selValid <= 1'b0;
      ledEnable <= 1'b0;
      integScale <= 3'h0;
    end else begin
      adcRoute <= decSel[2:0];
      selValid <= decSel[3];
      ledEnable <= normalMode && decSel[3] &&
        (state_reg == ST_CONV); // R03
      integScale <= gainExp; // R13
    end
  end

  // Ambient result alignment: low 16 or upper 16 of the 17-bit value
  // Only the ambient visible result is aligned here; the low alignment
  // keeps fine resolution but drops the top bit of a bright reading
  always @(posedge sys_clk) begin
    if (srst) begin
      ambientResult <= 16'h0000;
      ambientResultValid <= 1'b0;
    end else begin
      ambientResultValid <= convRawValid && ambientVisActive;
      if (convRawValid && ambientVisActive) begin
        if (ambEnc_reg[`PAIS_ALIGN_BIT]) begin
          ambientResult <= convRaw[15:0]; // R01
        end else begin
          ambientResult <= convRaw[16:1]; // R01
        end
      end
    end
  end

  // ***************************************************************
  // Read port
  // ***************************************************************

  // Read mux; unmapped offsets answer zero
  // Status is a debug view of selector legality and sequencer state
  always @* begin
    case (regAddr)
      `PAIS_OFF_AMB_ENC: rdData_next = ambEnc_reg;
      `PAIS_OFF_PROX1_SEL: rdData_next = prox1Sel_reg;
      `PAIS_OFF_PROX2_SEL: rdData_next = prox2Sel_reg;
      `PAIS_OFF_PROX3_SEL: rdData_next = prox3Sel_reg;
      `PAIS_OFF_REC_CNT: rdData_next = recCnt_reg;
      `PAIS_OFF_GAIN: rdData_next = gain_reg;
      `PAIS_OFF_MISC: rdData_next = misc_reg;
      `PAIS_OFF_STATUS: rdData_next = {3'h0, selValid, 2'h0, state_reg};
      default: rdData_next = 8'h00;
    endcase
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always @(posedge sys_clk) begin
    if (srst) begin
      regRdData <= 8'h00;
    end else if (regRdStb) begin
      regRdData <= rdData_next;
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule

// ---- testbench/pais_properties.sv ----
// Checker of timing, alignment and mode rules at the select block ports
`timescale 1ns/1ps
module pais_properties #(
  parameter TICK_CYC = 10
) (
  input wire sys_clk,
  input wire srst,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  input wire [7:0] regRdData,
  input wire convStart,
  input wire [16:0] convRaw,
  input wire convRawValid,
  input wire ambientVisActive,
  input wire recoveryBusy,
  input wire recoveryDone,
  input wire ledEnable,
  input wire [15:0] ambientResult,
  input wire ambientResultValid,
  input wire [2:0] integScale
);
  // ****
  // Shadow state
  // ****
  logic alignReg, modeReg;
  logic [2:0] gainReg, recReg;
  logic [19:0] busyCnt;
  int expCyc;
  // Mirror host writes so no design internals are needed
  always @(posedge sys_clk) begin
    if (srst) begin
      alignReg <= 1'b0;
      modeReg <= 1'b1;
      gainReg <= 3'h0;
      recReg <= 3'h7;
    end else if (regWrStb) begin
      if (regAddr == 8'h06) alignReg <= regWrData[4];
      if (regAddr == 8'h0c) modeReg <= regWrData[2];
      if (regAddr == 8'h0b) gainReg <= regWrData[2:0];
      if (regAddr == 8'h0a) recReg <= regWrData[6:4];
    end
  end
  // Busy length; cleared while idle so each recovery counts afresh
  always @(posedge sys_clk) begin
    busyCnt <= (recoveryBusy && !srst) ? busyCnt + 20'h1 : 20'h0;
  end
  assign expCyc = (recReg == 3'h0 ? 1 : (4 << recReg) - 1) * TICK_CYC
    << gainReg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_rd_data_idle:
    assert property (!regRdStb |=> regRdData == 8'h00)
    else $error("read data not zero");
  a_result_valid:
    assert property (convRawValid && ambientVisActive |=> ambientResultValid)
    else $error("ambient result valid missing");
  a_align_value:
    assert property (convRawValid && ambientVisActive |=> ambientResult ==
      (alignReg ? $past(convRaw[15:0]) : $past(convRaw[16:1])))
    else $error("ambient result misaligned");
  a_busy_start:
    assert property ($rose(recoveryBusy) |-> $past(convStart))
    else $error("recovery began without start");
  a_done_pulse:
    assert property (recoveryDone |-> $fell(recoveryBusy) ##1 !recoveryDone)
    else $error("recovery done not a single pulse");
  a_rec_length:
    assert property (recoveryDone |-> busyCnt + 2 >= expCyc &&
      busyCnt <= expCyc + 1)
    else $error("recovery length wrong");
  a_led_raw_off:
    assert property (!modeReg && !$past(modeReg) |-> !ledEnable)
    else $error("LED driven in raw mode");
  a_gain_copy:
    assert property ($stable(gainReg) |-> integScale == gainReg)
    else $error("integration scale differs from gain");
endmodule
bind pais_input_select pais_properties #(.TICK_CYC(TICK_CYC)) i_props (
  .sys_clk(sys_clk), .srst(srst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData(regRdData), .convStart(convStart), .convRaw(convRaw),
  .convRawValid(convRawValid), .ambientVisActive(ambientVisActive),
  .recoveryBusy(recoveryBusy), .recoveryDone(recoveryDone),
  .ledEnable(ledEnable), .ambientResult(ambientResult),
  .ambientResultValid(ambientResultValid), .integScale(integScale)
);

// ---- testbench/pais_host_model.sv ----
// Host model that programs the select block over its register port
`timescale 1ns/1ps
module pais_host_model (
  input wire sys_clk,
  input wire [7:0] regRdData,
  output logic [7:0] regAddr = 8'h00,
  output logic [7:0] regWrData = 8'h00,
  output logic regWrStb = 1'b0,
  output logic regRdStb = 1'b0
);
  // ****
  // Bus cycles
  // ****
  // One-cycle write; a gap cycle follows so strobes never collide
  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic regRead(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1;
    d = regRdData;
  endtask
  // Recovery as complement of gain keeps total settle time near constant for gains 0 to 6
  function automatic logic [7:0] recFor(input logic [2:0] g);
    return {1'b0, ~g, 4'h0};
  endfunction
  // Visible reading is negative; negate visible minus no-photodiode
  function automatic logic [15:0] visLight(input logic [15:0] v, z);
    return z - v;
  endfunction
  // Temperature and supply are only meaningful against a ground reading
  function automatic logic [15:0] lessGnd(input logic [15:0] r, gnd);
    return r - gnd;
  endfunction
endmodule

// ---- testbench/test_pais_input_select.sv ----
// Self-checking bench for the proximity input select block
`timescale 1ns/1ps
module test_pais_input_select;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  wire [7:0] regAddr, regWrData, regRdData;
  wire regWrStb, regRdStb;
  logic convStart = 1'b0;
  logic [1:0] convChannel = 2'h0;
  logic [16:0] convRaw = 17'h1a5c3;
  logic convRawValid = 1'b0;
  logic ambientVisActive = 1'b0;
  wire [2:0] adcRoute, integScale;
  wire selValid, ledEnable, recoveryBusy, recoveryDone, ambientResultValid;
  wire [15:0] ambientResult;
  int fail_count = 0;
  int cmp_count = 0;
  // Raw-mode {valid, route}; only the first two codes stay legal in normal
  localparam logic [3:0] RAWX [8] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd,
    4'he, 4'h7};
  localparam logic [7:0] CODES [8] = '{8'h00, 8'h03, 8'h02, 8'h06, 8'h25,
    8'h65, 8'h75, 8'h11};
  always #2.5 sys_clk = ~sys_clk;
  pais_host_model i_host (.sys_clk(sys_clk), .regRdData(regRdData),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb));
  pais_input_select #(.TICK_CYC(2)) i_dut (.sys_clk(sys_clk), .srst(srst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .convStart(convStart),
    .convChannel(convChannel), .convRaw(convRaw),
    .convRawValid(convRawValid), .ambientVisActive(ambientVisActive),
    .adcRoute(adcRoute), .selValid(selValid), .ledEnable(ledEnable),
    .recoveryBusy(recoveryBusy), .recoveryDone(recoveryDone),
    .ambientResult(ambientResult), .ambientResultValid(ambientResultValid),
    .integScale(integScale));
  // ****
  // Helpers and scenarios
  // ****
  task automatic check(input string what, input logic [15:0] e, s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, e);
    logic [7:0] d;
    i_host.regRead(a, d);
    check("register", {8'h00, e}, {8'h00, d});
  endtask
  task automatic test_done;
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reset values, reserved bits and an unmapped place
  task automatic regsTest;
    rdChk(8'h0d, 8'h10);
    rdChk(8'h0b, 8'h00);
    rdChk(8'h06, 8'h00);
    rdChk(8'h07, 8'h03);
    rdChk(8'h08, 8'h03);
    rdChk(8'h09, 8'h03);
    rdChk(8'h0a, 8'h70);
    rdChk(8'h0c, 8'h04);
    rdChk(8'h3f, 8'h00);
    i_host.regWrite(8'h0a, 8'hff);
    rdChk(8'h0a, 8'h70);
    i_host.regWrite(8'h06, 8'hff);
    rdChk(8'h06, 8'h10);
  endtask
  // Host arithmetic on raw readings
  task automatic hostTest;
    check("visible", 16'h0040, i_host.visLight(16'hff80, 16'hffc0));
    check("ground", 16'h0120, i_host.lessGnd(16'h0150, 16'h0030));
  endtask
  // Channel is latched only by a start; run a short recovery to move it
  task automatic pickChan(input logic [1:0] ch);
    convChannel <= ch;
    convStart <= 1'b1;
    @(posedge sys_clk);
    convStart <= 1'b0;
    repeat (6) @(posedge sys_clk);
    convRawValid <= 1'b1;
    @(posedge sys_clk);
    convRawValid <= 1'b0;
  endtask
  // Every code on every channel in both modes
  task automatic routeTest;
    i_host.regWrite(8'h0a, 8'h00);
    for (int m = 0; m < 2; m++) begin
      i_host.regWrite(8'h0c, m[0] ? 8'h04 : 8'h00);
      for (int ch = 0; ch < 3; ch++) begin
        pickChan(ch[1:0]);
        for (int i = 0; i < 8; i++) begin
          i_host.regWrite(8'h07 + ch[7:0], CODES[i]);
          repeat (3) @(posedge sys_clk);
          #1;
          check("route", {12'h0, (m && i > 1) ? 4'h7 : RAWX[i]},
            {12'h0, selValid, adcRoute});
        end
      end
    end
  endtask
  // Recovery length, a refused second start, LED window and alignment
  task automatic recTest(input logic [2:0] g, input logic m, al);
    int n;
    int expN;
    expN = (g == 3'h7 ? 1 : (4 << (~g & 7)) - 1) * 2 << g;
    i_host.regWrite(8'h07, 8'h03);
    i_host.regWrite(8'h0b, {5'h0, g});
    i_host.regWrite(8'h0a, i_host.recFor(g));
    i_host.regWrite(8'h0c, {5'h0, m, 2'h0});
    i_host.regWrite(8'h06, {3'h0, al, 4'h0});
    convChannel <= 2'h0;
    ambientVisActive <= 1'b1;
    convStart <= 1'b1;
    repeat (2) @(posedge sys_clk);
    convStart <= 1'b0;
    n = 1;
    #1;
    while (recoveryDone !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("span ok", 16'h1, 16'(n >= expN - 1 && n <= expN + 2));
    check("scale", {13'h0, g}, {13'h0, integScale});
    @(posedge sys_clk);
    #1;
    check("led", {15'h0, m}, {15'h0, ledEnable});
    @(posedge sys_clk);
    convRawValid <= 1'b1;
    @(posedge sys_clk);
    convRawValid <= 1'b0;
    #1;
    check("valid", 16'h1, {15'h0, ambientResultValid});
    check("result", al ? convRaw[15:0] : convRaw[16:1], ambientResult);
    @(posedge sys_clk);
    ambientVisActive <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("default", {12'h0, selValid, adcRoute}, 16'h9);
    regsTest();
    hostTest();
    routeTest();
    recTest(3'h5, 1'b1, 1'b0);
    recTest(3'h3, 1'b0, 1'b1);
    recTest(3'h0, 1'b1, 1'b1);
    test_done();
  end
  // Watchdog well beyond the roughly 3400 cycles needed
  initial begin
    repeat (50000) @(posedge sys_clk);
    fail_count++;
    $display("FAIL watchdog expected finish seen timeout");
    test_done();
  end
endmodule
